/* pkg/sipo_shifter_pkg.sv */
// Constants shared by the serial-in parallel-out shifter and its output FIFO
package sipo_shifter_pkg;

   // ***************************************************************
   // Geometry
   // ***************************************************************
   localparam int STAGE_COUNT = 8;
   localparam logic [7:0] STAGES_RESET = 8'h00;
   localparam int SYNC_DEPTH = 2;

   // ***************************************************************
   // Output buffering
   // ***************************************************************
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = STAGE_COUNT;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CORE_CLK_PERIOD_NS = 10;
   // Least time from clear release to the first honoured shift edge
   localparam int CLEAR_RECOVERY_NS = 20;
   localparam int CLEAR_RECOVERY_CYCLES =
      (CLEAR_RECOVERY_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
   localparam logic [3:0] RECOVERY_RESET = 4'h0;

endpackage

/* verilog/word_fifo.sv */
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_core_clk, // Core clock
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic i_valid, // Write side offers a word
   input wire logic [WIDTH-1:0] i_data, // Word to write
   output logic o_ready, // Space for a word
   output logic o_valid, // A word is available
   output logic [WIDTH-1:0] o_data, // Oldest word
   input wire logic i_ready, // Read side takes the word
   output logic [$clog2(DEPTH+1)-1:0] o_level // Words held
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [CW-1:0] count;
   } fifo_state_type;

   fifo_state_type st_q;
   fifo_state_type st_d;
   logic do_wr;
   logic do_rd;

   assign o_ready = (st_q.count != CW'(DEPTH));
   assign o_valid = (st_q.count != '0);
   assign o_data = st_q.mem[st_q.rd_ptr];
   assign o_level = st_q.count;
   assign do_wr = i_valid & o_ready;
   assign do_rd = i_ready & o_valid;

   always_comb
   begin
      st_d = st_q;
      if (do_wr)
      begin
         st_d.mem[st_q.wr_ptr] = i_data;
         st_d.wr_ptr = (st_q.wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(st_q.wr_ptr + 1'b1);
      end
      if (do_rd)
      begin
         st_d.rd_ptr = (st_q.rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(st_q.rd_ptr + 1'b1);
      end
      if (do_wr && !do_rd)
      begin
         st_d.count = CW'(st_q.count + 1'b1);
      end
      else if (do_rd && !do_wr)
      begin
         st_d.count = CW'(st_q.count - 1'b1);
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

endmodule // word_fifo

/* verilog/sipo_shifter.sv */
// Eight-stage serial-in parallel-out shifter sampled from pins, with output word FIFO
`timescale 1ns/1ps
module sipo_shifter #(
   parameter int STAGES = sipo_shifter_pkg::STAGE_COUNT,
   parameter int DEPTH = sipo_shifter_pkg::FIFO_DEPTH
) (
   input wire logic i_core_clk, // Core clock, 100 MHz
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic i_shift_clock, // Shift clock pin, rising edge active
   input wire logic i_clear_n, // Clear pin, active low
   input wire logic i_serial_a, // Serial data input A
   input wire logic i_serial_b, // Serial data input B
   output logic [STAGES-1:0] o_stage_outputs, // Parallel stage outputs
   output logic o_stage_out_first, // First stage output
   output logic o_clearing, // Clear seen active
   output logic o_overrun, // Pulse: shift edge dropped, FIFO full
   output logic o_word_valid, // Captured word available
   output logic [STAGES-1:0] o_word_data, // Oldest captured word
   input wire logic i_word_ready, // Downstream takes the word
   output logic [$clog2(DEPTH+1)-1:0] o_word_level // Words waiting
);

   // ***************************************************************
   // State
   // ***************************************************************
   // Pins in synchroniser order: shift clock, clear, serial A, serial B
   localparam int PINS = 4;

   typedef struct packed {
      logic [PINS-1:0][sipo_shifter_pkg::SYNC_DEPTH-1:0] pin_sync;
      logic clk_prev;
      logic a_prev;
      logic b_prev;
      logic [STAGES-1:0] stages;
      logic [3:0] recovery;
      logic push_valid;
      logic [STAGES-1:0] push_data;
      logic overrun;
   } shifter_state_type;

   shifter_state_type st_q;
   shifter_state_type st_d;

   logic clk_s;
   logic clr_n_s;
   logic a_s;
   logic b_s;
   logic shift_edge;
   logic fifo_ready;
   logic stall;
   logic serial_bit;
   logic clear_active;
   logic recovering;
   logic edge_open;
   logic take_edge;
   logic drop_edge;
   logic [PINS-1:0] pin_raw;
   logic [PINS-1:0] pin_s;
   logic [PINS-1:0][sipo_shifter_pkg::SYNC_DEPTH-1:0] sync_d;
   logic [STAGES-1:0] shifted;

   localparam int TOP = sipo_shifter_pkg::SYNC_DEPTH - 1;
   localparam logic [3:0] RECOVERY_LOAD = 4'(sipo_shifter_pkg::CLEAR_RECOVERY_CYCLES);

   // ***************************************************************
   // Pin conditioning
   // ***************************************************************
   // Bit order fixes which synchroniser serves which pin
   assign pin_raw = {i_serial_b, i_serial_a, i_clear_n, i_shift_clock};

   // Two flops per pin; only the last one is looked at by any logic
   for (genvar p = 0; p < PINS; p++)
   begin : g_sync
      assign sync_d[p] = {st_q.pin_sync[p][TOP-1:0], pin_raw[p]};
      assign pin_s[p] = st_q.pin_sync[p][TOP];
   end

   assign {b_s, a_s, clr_n_s, clk_s} = pin_s;

   // The pin clock is oversampled, so it must stay well below the core rate
   assign shift_edge = clk_s & ~st_q.clk_prev;

   // A word still waiting for FIFO space blocks the next shift
   assign stall = st_q.push_valid & ~fifo_ready;

   // gated serial entry
   // Data synchronised one sample before the edge, as it stood prior to it
   assign serial_bit = st_q.a_prev & st_q.b_prev;

   // ***************************************************************
   // Stage shifting
   // ***************************************************************
   // one place up
   // Stage zero takes the gated bit, every other stage its lower neighbour
   for (genvar s = 0; s < STAGES; s++)
   begin : g_stage
      if (s == 0)
      begin : g_entry
         assign shifted[s] = serial_bit;
      end
      else
      begin : g_move
         assign shifted[s] = st_q.stages[s-1];
      end
   end

   // ***************************************************************
   // Edge decode
   // ***************************************************************
   // clear overrides
   assign clear_active = ~clr_n_s;
   // Edges inside the recovery time after clear are not honoured
   assign recovering = (st_q.recovery != 4'h0);
   assign edge_open = shift_edge & ~clear_active & ~recovering;
   // Dropping the edge keeps stages and FIFO contents consistent
   assign take_edge = edge_open & ~stall;
   assign drop_edge = edge_open & stall;

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb
   begin
      st_d = st_q;
      st_d.pin_sync = sync_d;
      st_d.clk_prev = clk_s;
      st_d.a_prev = a_s;
      st_d.b_prev = b_s;
      st_d.overrun = 1'b0;
      if (fifo_ready)
      begin
         st_d.push_valid = 1'b0;
      end
      if (clear_active)
      begin
         st_d.stages = sipo_shifter_pkg::STAGES_RESET[STAGES-1:0];
         st_d.recovery = RECOVERY_LOAD;
      end
      else if (recovering)
      begin
         st_d.recovery = 4'(st_q.recovery - 4'h1);
      end
      if (drop_edge)
      begin
         st_d.overrun = 1'b1;
      end
      if (take_edge)
      begin
         st_d.stages = shifted;
         // The word waits here until the FIFO has room for it
         st_d.push_valid = 1'b1;
         st_d.push_data = shifted;
      end
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   // Sync reset holds clear active, so recovery runs before the first edge
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         st_q.pin_sync <= '0;
         st_q.clk_prev <= 1'b0;
         st_q.a_prev <= 1'b0;
         st_q.b_prev <= 1'b0;
         st_q.stages <= sipo_shifter_pkg::STAGES_RESET[STAGES-1:0];
         st_q.recovery <= sipo_shifter_pkg::RECOVERY_RESET;
         st_q.push_valid <= 1'b0;
         st_q.push_data <= '0;
         st_q.overrun <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   // parallel stage outputs
   assign o_stage_outputs = st_q.stages;
   assign o_stage_out_first = st_q.stages[0];
   assign o_clearing = ~clr_n_s;
   assign o_overrun = st_q.overrun;

   // ***************************************************************
   // Output word buffer
   // ***************************************************************
   // Clear leaves words already captured in the FIFO
   word_fifo #(
      .WIDTH(STAGES),
      .DEPTH(DEPTH)
   ) u_word_fifo (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_valid(st_q.push_valid),
      .i_data(st_q.push_data),
      .o_ready(fifo_ready),
      .o_valid(o_word_valid),
      .o_data(o_word_data),
      .i_ready(i_word_ready),
      .o_level(o_word_level)
   );

endmodule // sipo_shifter

/* test/sipo_shifter_asserts.sv */
// Port checker for the serial-in parallel-out shifter
`timescale 1ns/1ps
module sipo_shifter_asserts #(
   parameter int STAGES = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_core_clk, // Core clock
   input wire logic i_rst, // Sync reset
   input wire logic i_clear_n, // Clear pin
   input wire logic i_serial_a, // Serial A
   input wire logic i_serial_b, // Serial B
   input wire logic [STAGES-1:0] o_stage_outputs, // Stages
   input wire logic o_stage_out_first, // First stage
   input wire logic o_clearing // Clear seen
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // Stages moved by a shift, not by a clear
   sequence s_shift;
      !$stable(o_stage_outputs) && !o_clearing;
   endsequence
   AST_FIRST_COPY: assert property (o_stage_out_first == o_stage_outputs[0])
      else $error("first output differs from stage zero");
   AST_SHIFT_UP: assert property (s_shift |->
      o_stage_outputs[STAGES-1:1] == $past(o_stage_outputs[STAGES-2:0]))
      else $error("stages did not move up by one");
   // Entry bit sampled four core cycles earlier, data held steady around it
   AST_ENTRY_AND: assert property (s_shift |->
      o_stage_outputs[0] == $past(i_serial_a & i_serial_b, 4))
      else $error("entered bit is not the AND of the inputs");
   AST_CLEAR_SEEN: assert property ($fell(i_clear_n) |-> ##[1:4] o_clearing)
      else $error("clear not seen in time");
   AST_CLEAR_ZERO: assert property (o_clearing |=> o_stage_outputs == '0)
      else $error("stages not low during clear");
endmodule // sipo_shifter_asserts

bind sipo_shifter sipo_shifter_asserts #(.STAGES(STAGES), .DEPTH(DEPTH)) u_asserts (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_clear_n(i_clear_n),
   .i_serial_a(i_serial_a), .i_serial_b(i_serial_b), .o_stage_outputs(o_stage_outputs),
   .o_stage_out_first(o_stage_out_first), .o_clearing(o_clearing));

/* test/pin_driver.sv */
// Upstream logic model driving shift clock, clear and serial data pins
`timescale 1ns/1ps
module pin_driver (
   input wire logic i_core_clk, // Core clock
   output logic o_shift_clock, // Shift clock pin
   output logic o_clear_n, // Clear pin, active low
   output logic o_serial_a, // Serial data A
   output logic o_serial_b // Serial data B
);
   initial
   begin
      o_shift_clock = 1'b0;
      o_clear_n = 1'b0;
      o_serial_a = 1'b1;
      o_serial_b = 1'b1;
   end
   task automatic shift(input logic a, input logic b);
      o_serial_a <= a;
      o_serial_b <= b;
      repeat (3) @(posedge i_core_clk);
      o_shift_clock <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      o_shift_clock <= 1'b0;
      repeat (4) @(posedge i_core_clk);
   endtask
   task automatic set_clear(input logic lvl);
      o_clear_n <= lvl;
   endtask
endmodule // pin_driver

/* test/tb_sipo_shifter.sv */
// Self-checking bench for the serial-in parallel-out shifter
`timescale 1ns/1ps
module tb_sipo_shifter;
   logic clk, rst, rdy, ovr_q, sclk, clr_n, sa, sb, first, clearing, ovr, wvalid;
   logic [7:0] stages, wdata, exp_q;
   logic [4:0] level;
   logic [7:0] words[$];
   int failures, checks;
   pin_driver u_drv (.i_core_clk(clk), .o_shift_clock(sclk), .o_clear_n(clr_n),
      .o_serial_a(sa), .o_serial_b(sb));
   sipo_shifter u_dut (.i_core_clk(clk), .i_rst(rst), .i_shift_clock(sclk),
      .i_clear_n(clr_n), .i_serial_a(sa), .i_serial_b(sb), .o_stage_outputs(stages),
      .o_stage_out_first(first), .o_clearing(clearing), .o_overrun(ovr),
      .o_word_valid(wvalid), .o_word_data(wdata), .i_word_ready(rdy), .o_word_level(level));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (rst)
         ovr_q <= 1'b0;
      else if (ovr)
         ovr_q <= 1'b1;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
      end
   endtask
   task automatic do_shift(input logic a, input logic b);
      u_drv.shift(a, b);
      exp_q = {exp_q[6:0], a & b};
      words.push_back(exp_q);
      check(stages, exp_q);
      check({7'h00, first}, {7'h00, exp_q[0]});
   endtask
   task automatic t_gates;
      for (int i = 3; i >= 0; i--) do_shift(i[1], i[0]);
      $display("test gates done");
   endtask
   task automatic t_clear;
      u_drv.set_clear(1'b0);
      repeat (5) @(posedge clk);
      check({7'h00, clearing}, 8'h01);
      u_drv.shift(1'b1, 1'b1);
      check(stages, 8'h00);
      check({3'h0, level}, 8'h04);
      u_drv.set_clear(1'b1);
      repeat (8) @(posedge clk);
      check({7'h00, clearing}, 8'h00);
      exp_q = 8'h00;
      $display("test clear done");
   endtask
   task automatic t_fill;
      for (int i = 4; i < 16; i++) do_shift(i[0] | i[2], 1'b1);
      check({3'h0, level}, 8'h10);
      check({7'h00, ovr_q}, 8'h00);
      // Full FIFO: one more word waits at the push stage, the next edge is dropped
      do_shift(1'b1, 1'b1);
      u_drv.shift(1'b1, 1'b1);
      check(stages, exp_q);
      check({7'h00, ovr_q}, 8'h01);
      check({3'h0, level}, 8'h10);
      $display("test fill done");
   endtask
   task automatic t_drain;
      rdy <= 1'b1;
      for (int n = 0; n < 40 && words.size() > 0; n++)
      begin
         @(negedge clk);
         check({7'h00, wvalid}, 8'h01);
         if (wvalid === 1'b1) check(wdata, words.pop_front());
         @(posedge clk);
      end
      if (words.size() > 0) failures++;
      rdy <= 1'b0;
      @(posedge clk);
      check({3'h0, level}, 8'h00);
      check({7'h00, wvalid}, 8'h00);
      $display("test drain done");
   endtask
   task automatic results;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      rdy = 1'b0;
      exp_q = 8'h00;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      u_drv.set_clear(1'b1);
      repeat (8) @(posedge clk);
      check(stages, 8'h00);
      t_gates();
      t_clear();
      t_fill();
      t_drain();
      results();
   end
endmodule // tb_sipo_shifter
